/* bench/bts_far.sv */
/*
  Receiver-side radio stand-in: channel busy flag and symbol bits.
  Assumes the sequencer clock; busy follows the bench's hold input.
*/
`timescale 1ns/1ps
`default_nettype none
module bts_far (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_hold,
  // Sequencer side
  input  wire logic i_bit_req,
  output var  logic o_busy,
  output var  logic o_bit
);
  initial o_bit = 1'b0;
  // A fresh bit on every request so stale symbols show up
  always @(posedge i_clk) begin
    o_busy <= i_hold;
    if (i_bit_req) begin
      o_bit <= ~o_bit;
    end
  end
endmodule
`default_nettype wire

/* bench/bts_seq_tb.sv */
/*
  Bench of the sequencer: registers, one active burst without lock, distress.
  Assumes shortened second and slot counts.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module bts_seq_tb import bts_pkg::*; ;
  localparam int SC = 500;
  localparam int SL = 20;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pps = 0, hold = 1;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, d, seed = 32'h3bb5;
  logic [1:0] r, br, rr;
  logic [2:0] off;
  logic awr, wr, bv, arr, rv, busy, dbit, breq, dk, key, chb, m14, tt;
  logic [31:0] rd;
  logic [3:0] nav;
  logic [26:0] lat;
  logic [26:0] plat = 0;
  logic lock = 0, fix = 0, sc = 0, stb = 0, us, kl;
  logic [2:0] lh;
  int n_fail = 0, n_compared = 0, cyc = 0, t0, tk, tp, n;
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seed <= xs(seed);
    pps <= (cyc % SC) == 0;
    if (cyc == 80000) begin
      n_fail++;
      finish_test();
    end
  end
  // Leap flag crosses two sync flops and one output flop
  always @(posedge clk) begin
    lh <= {lh[1:0], seed[9]};
    if (cyc > 20) `CHK(kl, lh[2])
  end
  // Loops key on a local flag: a strobe set by NBA still reads old here
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, v, 3'b111};
    while (!done) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) begin
        bry <= 1'b0;
        done = 1'b1;
        `CHK(br, RESP_OKAY)
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [1:0] s, output logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    while (!done) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        rry <= 1'b0;
        s = rr;
        v = rd;
        done = 1'b1;
      end
    end
  endtask
  bts_far bts_far_i (.i_clk(clk), .i_hold(hold), .i_bit_req(breq), .o_busy(busy), .o_bit(dbit));
  bts_seq #(.P_SEC_CYC(SC), .P_SLOT_CYC(SL), .P_WDOG_CYC(60), .P_BAUD_CYC(40), .P_HALF_Y(8),
    .P_HALF_B(5)) bts_seq_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_axi_awaddr(awa),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
    .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(br), .o_axi_bvalid(bv),
    .i_axi_bready(bry), .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .o_axi_rdata(rd), .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rry),
    .i_utc_pps(pps), .i_utc_lock(lock), .i_fix_valid(fix), .i_sogcog_valid(sc),
    .i_leap_valid(seed[9]), .i_pos_strobe(stb), .i_lat(plat), .i_lon(seed[31:4]),
    .o_pos_req(), .o_keep_leap(kl), .i_dsc_busy(busy), .i_dsc_bit(dbit), .o_dsc_key(dk),
    .o_dsc_tone(), .o_dsc_bit_req(breq), .o_tx_key(key), .o_tx_chan_b(chb),
    .o_tx_msg14(m14), .o_tx_text_test(tt), .o_tx_unsync(us), .o_nav_status(nav),
    .o_lat(lat), .o_lon());
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    axr(8'h40, r, d);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    off = seed[2:0];
    axw(ADDR_SLOTOFF, {29'h0, off});
    axr(ADDR_SLOTOFF, r, d);
    `CHK({r, d}, {RESP_OKAY, 29'h0, off})
    axw(ADDR_DSCLEN, 32'h1);
    axw(ADDR_CTRL, 32'h5);
    t0 = cyc;
    $display("test registers done");
    // Optional unsynchronized default transmission on the first channel
    while (key !== 1'b1) @(posedge clk);
    `CHK(cyc - t0 inside {[10*SC : 10*SC+SL+4]}, 1'b1)
    `CHK({us, chb, m14}, 3'b100)
    while (key === 1'b1) @(posedge clk);
    // No lock and no fix: start falls back on the activation limit
    for (int i = 0; i < 8; i++) begin
      while (key !== 1'b1) @(posedge clk);
      tk = cyc;
      if (i == 0) `CHK(tk - t0 inside {[60*SC-4 : 60*SC+(off+2)*SL+4]}, 1'b1)
      else `CHK(tk - tp, 75*SL)
      `CHK(chb, i[0])
      `CHK(m14, logic'(i == 4 || i == 5))
      `CHK({nav, tt, us}, {NAV_ACTIVE, 2'b00})
      `CHK(lat, LAT_NA)
      tp = tk;
      while (key === 1'b1) @(posedge clk);
      `CHK(cyc - tk, SL)
    end
    $display("test burst done");
    // A stored fix survives the loss of the fix
    {fix, sc, stb, plat} <= {3'b111, seed[26:0]};
    repeat (5) @(posedge clk);
    {fix, sc, stb} <= 3'b000;
    repeat (5) @(posedge clk);
    `CHK(lat, plat)
    axw(ADDR_CTRL, 32'h9);
    repeat (20) @(posedge clk);
    `CHK(dk, 1'b0)
    hold <= 1'b0;
    n = 0;
    while (dk !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK(dk, 1'b1)
    n = 0;
    while (dk === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(n inside {[40:42]}, 1'b1)
    $display("test distress done");
    finish_test();
  end
endmodule
`default_nettype wire

/* hw/bts_fsk_gen.sv */
/*
  Sub-carrier tone generator for distress signalling symbols.
  Assumes the controller updates sym in the cycle after each sym_req.
*/
`timescale 1ns/1ps
`default_nettype none
module bts_fsk_gen import bts_pkg::*; #(
  parameter int BAUD_N = BAUD_CYC,
  parameter int HALF_Y = TONE_Y_HALF,
  parameter int HALF_B = TONE_B_HALF
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Controller side
  bts_fsk_if.gen   fsk
);
  logic [15:0] baud_q;
  logic [15:0] ph_q;
  logic [15:0] half;
  logic        req_q;
  logic        tone_q;

  assign fsk.sym_req = req_q;
  assign fsk.tone    = tone_q;
  // B-state is the high tone, Y-state the low one
  assign half = fsk.sym ? 16'(HALF_B - 1) : 16'(HALF_Y - 1);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !fsk.key) begin
      baud_q <= '0;
      req_q  <= '0;
    end else if (baud_q == 16'(BAUD_N - 1)) begin
      baud_q <= '0;
      req_q  <= '1;
    end else begin
      baud_q <= baud_q + 16'h0001;
      req_q  <= '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !fsk.key) begin
      ph_q   <= '0;
      tone_q <= '0;
    end else if (ph_q >= half) begin
      ph_q   <= '0;
      tone_q <= ~tone_q;
    end else begin
      ph_q   <= ph_q + 16'h0001;
    end
  end

  chk_baud_pulse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    req_q |=> !req_q) else $error("symbol request lasted more than a cycle");
endmodule
`default_nettype wire

/* hw/bts_fsk_if.sv */
/*
  Link between the sequencer and the sub-carrier tone generator.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface bts_fsk_if;
  logic key;
  logic sym;
  logic sym_req;
  logic tone;
  modport ctl (output key, output sym, input sym_req, input tone);
  modport gen (input key, input sym, output sym_req, output tone);
endinterface
`default_nettype wire

/* hw/bts_pkg.sv */
/*
  Constants, register map and state type of the beacon transmit sequencer.
  Assumes a 20 MHz system clock; all cycle counts derive from it.
*/
package bts_pkg;
  localparam int CLK_HZ        = 20_000_000;
  localparam int SEC_CYC       = CLK_HZ;
  localparam int WDOG_MS       = 2000;
  localparam int WDOG_CYC      = CLK_HZ / 1000 * WDOG_MS;
  localparam int FRAME_MS      = 2000;
  localparam int FRAME_SLOTS   = 75;
  localparam int SLOT_CYC      = CLK_HZ / 1000 * FRAME_MS / FRAME_SLOTS;
  localparam int TONE_Y_HZ     = 1300;
  localparam int TONE_B_HZ     = 2100;
  localparam int BAUD          = 1200;
  localparam int TONE_Y_HALF   = CLK_HZ / (2 * TONE_Y_HZ);
  localparam int TONE_B_HALF   = CLK_HZ / (2 * TONE_B_HZ);
  localparam int BAUD_CYC      = CLK_HZ / BAUD;
  localparam int START_LIM_S   = 60;
  localparam int UNSYNC_MIN_S  = 10;
  localparam int UNSYNC_MAX_S  = 30;
  localparam int SYNC_LIM_MIN  = 5;
  localparam int SYNC_LIM_S    = SYNC_LIM_MIN * 60;
  localparam int TEST_LIM_MIN  = 5;
  localparam int TEST_LIM_S    = TEST_LIM_MIN * 60;
  localparam int POS_REQ_S     = 60;
  localparam int BURST_LEN     = 8;
  localparam int TX_GAP_SLOTS  = 75;
  localparam int MINUTE_SLOTS  = 60 * FRAME_SLOTS * 1000 / FRAME_MS;
  localparam logic [3:0]  NAV_ACTIVE = 4'he;
  localparam logic [3:0]  NAV_TEST   = 4'hf;
  // Not-available defaults, 1/10000 minute units
  localparam logic [26:0] LAT_NA     = 27'h3412140;
  localparam logic [27:0] LON_NA     = 28'h6891ac0;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_DSCLEN  = 8'h04;
  localparam logic [7:0]  ADDR_SLOTOFF = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_LAT     = 8'h10;
  localparam logic [7:0]  ADDR_LON     = 8'h14;
  localparam logic [7:0]  ADDR_SECS    = 8'h18;
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_TEST   = 1;
  localparam int CTRL_UNSYNC = 2;
  localparam int CTRL_DSC_GO = 3;
  localparam logic [7:0]  DSCLEN_RST  = 8'h00;
  localparam logic [11:0] SLOTOFF_RST = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {S_OFF, S_WAIT, S_TWAIT, S_BURST, S_DONE} bts_state_t;
endpackage

/* hw/bts_seq.sv */
/*
  Beacon transmit sequencer: activation timers, AIS burst scheduling on two
  channels, distress signalling with listen before talk, stuck-key cutoff,
  AXI4-Lite register slave.
  Assumes satellite receiver and radio pins are asynchronous to the clock.
*/
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Distress signalling starts only while the distress channel senses idle.
// - Symbols key a low tone for Y-state, high tone for B-state, fixed baud.
// - Logic watchdog kills keying after two seconds continuous key.
// - Position bursts are slot scheduled on two channels.
// - Active mode reports navigational status 14 and active safety text.
// - Test mode reports navigational status 15 and test safety text.
// - Slot boundaries follow the receiver's UTC timing pulse.
// - After first fix, position is refreshed at least every minute.
// - Active bursts start when all data valid, else by 60 s.
// - Optional unsynchronized default transmission between 10 s and 30 s.
// - Synchronized transmission with real position expected within 5 minutes.
// - Once started, active transmission continues despite fix or lock loss.
// - Without lock, slot timing free runs on the internal time base.
// - Without fix, the last valid position keeps being sent.
// - Test mode sends exactly one burst once all data are valid.
// - Test burst needs fix, SOG/COG and UTC lock, not valid leap-second data.
// - Test mode aborts silently when no lock within five minutes.
// - Transmissions start on slot boundaries of a two second frame.
// - Receiver cold start may keep only valid leap-second data.
// - Eight transmissions per burst, 75 slots apart, alternating channels.
// - Active mode sends one burst of eight per minute.
// - Never fixed position reports the not-available defaults.
module bts_seq import bts_pkg::*; #(
  parameter int P_SEC_CYC  = SEC_CYC,
  parameter int P_SLOT_CYC = SLOT_CYC,
  parameter int P_WDOG_CYC = WDOG_CYC,
  parameter int P_BAUD_CYC = BAUD_CYC,
  parameter int P_HALF_Y   = TONE_Y_HALF,
  parameter int P_HALF_B   = TONE_B_HALF
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output var  logic        o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output var  logic        o_axi_wready,
  output var  logic [1:0]  o_axi_bresp,
  output var  logic        o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output var  logic        o_axi_arready,
  output var  logic [31:0] o_axi_rdata,
  output var  logic [1:0]  o_axi_rresp,
  output var  logic        o_axi_rvalid,
  input  wire logic        i_axi_rready,
  // Satellite receiver
  input  wire logic        i_utc_pps,
  input  wire logic        i_utc_lock,
  input  wire logic        i_fix_valid,
  input  wire logic        i_sogcog_valid,
  input  wire logic        i_leap_valid,
  input  wire logic        i_pos_strobe,
  input  wire logic [26:0] i_lat,
  input  wire logic [27:0] i_lon,
  output var  logic        o_pos_req,
  output var  logic        o_keep_leap,
  // Radio
  input  wire logic        i_dsc_busy,
  input  wire logic        i_dsc_bit,
  output var  logic        o_dsc_key,
  output var  logic        o_dsc_tone,
  output var  logic        o_dsc_bit_req,
  output var  logic        o_tx_key,
  output var  logic        o_tx_chan_b,
  output var  logic        o_tx_msg14,
  output var  logic        o_tx_text_test,
  output var  logic        o_tx_unsync,
  output var  logic [3:0]  o_nav_status,
  output var  logic [26:0] o_lat,
  output var  logic [27:0] o_lon
);
  bts_fsk_if fsk ();
  bts_fsk_gen #(.BAUD_N(P_BAUD_CYC), .HALF_Y(P_HALF_Y), .HALF_B(P_HALF_B)) u_gen (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .fsk       (fsk.gen)
  );

  logic [62:0] s1_q, s2_q;
  logic        pps_s, lock_s, fix_s, sc_s, leap_s, stb_s, busy_s, bit_s;
  logic [26:0] lat_s;
  logic [27:0] lon_s;
  logic        pps_d_q, run_d_q, par_q, act;
  logic        pps_rise, sec_tick, slot_tick, all_ok, fire, wr_go;
  logic [24:0] sec_cyc_q;
  logic [19:0] slot_cyc_q;
  logic [9:0]  secs_q;
  logic [5:0]  pos_age_q;
  logic        pos_ok_q;
  logic [25:0] wd_q;
  logic        wd_trip_q;
  bts_state_t  st_q;
  logic [11:0] wait_q;
  logic [2:0]  idx_q, bno_q;
  logic        test_q, started_q, synced_q, late_q, abandon_q, usent_q;
  logic [7:0]  awa_q, dsclen_q, symcnt_q;
  logic [31:0] wd_data_q;
  logic [3:0]  wstb_q;
  logic [3:0]  ctrl_q;
  logic [11:0] slotoff_q;
  logic        dsc_pend_q, sym_q;
  logic [7:0]  gap_q;
  logic        key_d_q;

  // Every receiver and radio pin passes two flops; lat/lon are stable around the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {i_utc_pps, i_utc_lock, i_fix_valid, i_sogcog_valid, i_leap_valid,
               i_pos_strobe, i_dsc_busy, i_dsc_bit, i_lat, i_lon};
      s2_q <= s1_q;
    end
  end
  assign {pps_s, lock_s, fix_s, sc_s, leap_s, stb_s, busy_s, bit_s, lat_s, lon_s} = s2_q;
  assign pps_rise  = pps_s && !pps_d_q;
  assign act       = ctrl_q[CTRL_RUN] && !run_d_q;
  assign sec_tick  = pps_rise && lock_s || sec_cyc_q == 25'(P_SEC_CYC - 1);
  assign slot_tick = slot_cyc_q == 20'(P_SLOT_CYC - 1);
  assign all_ok    = fix_s && sc_s && lock_s;

  // Internal time base, pulled into step by the timing pulse when locked
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pps_d_q    <= '0;
      run_d_q    <= '0;
      par_q      <= '0;
      sec_cyc_q  <= '0;
      slot_cyc_q <= '0;
    end else begin
      pps_d_q <= pps_s;
      run_d_q <= ctrl_q[CTRL_RUN];
      // Activation restarts the second phase so windows count from it
      sec_cyc_q <= (sec_tick || act) ? '0 : sec_cyc_q + 25'h0000001;
      if (pps_rise && lock_s) begin
        par_q <= ~par_q;
      end
      // Frame of 75 slots restarts on every second timing pulse
      if (pps_rise && lock_s && par_q || slot_tick) begin
        slot_cyc_q <= '0;
      end else begin
        slot_cyc_q <= slot_cyc_q + 20'h00001;
      end
    end
  end

  // Seconds since activation
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || act) begin
      secs_q <= '0;
    end else if (sec_tick && secs_q != 10'h3ff) begin
      secs_q <= secs_q + 10'h001;
    end
  end

  // Position store and refresh request
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || act) begin
      o_lat     <= LAT_NA;
      o_lon     <= LON_NA;
      pos_ok_q  <= '0;
      pos_age_q <= '0;
      o_pos_req <= '0;
    end else begin
      o_pos_req <= pos_ok_q && sec_tick && pos_age_q == 6'(POS_REQ_S - 1);
      if (stb_s && fix_s) begin
        o_lat     <= lat_s;
        o_lon     <= lon_s;
        pos_ok_q  <= '1;
        pos_age_q <= '0;
      end else if (sec_tick && pos_age_q != 6'(POS_REQ_S - 1)) begin
        pos_age_q <= pos_age_q + 6'h01;
      end
    end
  end

  // Stored leap data may survive a cold start only when valid
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_keep_leap <= '0;
    end else begin
      o_keep_leap <= leap_s;
    end
  end

  // Stuck-key cutoff, independent of software; latched until reset
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wd_q      <= '0;
      wd_trip_q <= '0;
    end else if (o_tx_key || o_dsc_key) begin
      wd_q <= wd_q + 26'h0000001;
      if (wd_q == 26'(P_WDOG_CYC - 1)) begin
        wd_trip_q <= '1;
      end
    end else begin
      wd_q <= '0;
    end
  end

  assign fire = st_q == S_BURST && slot_tick && wait_q == '0 && !wd_trip_q;

  // Mode sequencing and burst scheduling
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !ctrl_q[CTRL_RUN]) begin
      st_q      <= S_OFF;
      wait_q    <= '0;
      idx_q     <= '0;
      bno_q     <= '0;
      test_q    <= '0;
      started_q <= '0;
      synced_q  <= '0;
      usent_q   <= '0;
    end else begin
      unique case (st_q)
        S_OFF: begin
          test_q <= ctrl_q[CTRL_TEST];
          st_q   <= ctrl_q[CTRL_TEST] ? S_TWAIT : S_WAIT;
        end
        S_WAIT: begin
          if (all_ok || secs_q >= 10'(START_LIM_S)) begin
            st_q      <= S_BURST;
            wait_q    <= slotoff_q;
            started_q <= '1;
          end else if (slot_tick && ctrl_q[CTRL_UNSYNC] && !usent_q &&
                       secs_q >= 10'(UNSYNC_MIN_S) && secs_q < 10'(UNSYNC_MAX_S)) begin
            usent_q <= '1;
          end
        end
        S_TWAIT: begin
          if (all_ok) begin
            st_q   <= S_BURST;
            wait_q <= slotoff_q;
          end else if (!lock_s && secs_q >= 10'(TEST_LIM_S)) begin
            st_q <= S_DONE;
          end
        end
        S_BURST: begin
          // Loss of fix or lock does not leave this state
          if (fire) begin
            idx_q <= idx_q + 3'h1;
            if (all_ok) begin
              synced_q <= '1;
            end
            if (idx_q == 3'(BURST_LEN - 1)) begin
              bno_q  <= bno_q + 3'h1;
              wait_q <= 12'(MINUTE_SLOTS - (BURST_LEN - 1) * TX_GAP_SLOTS - 1);
              if (test_q) begin
                st_q <= S_DONE;
              end
            end else begin
              wait_q <= 12'(TX_GAP_SLOTS - 1);
            end
          end else if (slot_tick && wait_q != '0) begin
            wait_q <= wait_q - 12'h001;
          end
        end
        S_DONE: begin
          st_q <= S_DONE;
        end
      endcase
    end
  end

  // Transmitter keying: one slot per transmission, aligned to the slot tick
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || wd_trip_q) begin
      o_tx_key       <= '0;
      o_tx_chan_b    <= '0;
      o_tx_msg14     <= '0;
      o_tx_text_test <= '0;
      o_tx_unsync    <= '0;
      o_nav_status   <= NAV_ACTIVE;
    end else if (fire) begin
      o_tx_key       <= '1;
      o_tx_chan_b    <= idx_q[0];
      o_tx_unsync    <= '0;
      o_tx_text_test <= test_q;
      o_nav_status   <= test_q ? NAV_TEST : NAV_ACTIVE;
      // Safety text replaces position reports 5/6 of every fourth active burst from the first, 1 and 8 of the test burst
      o_tx_msg14 <= test_q ? (idx_q == 3'h0 || idx_q == 3'h7)
                           : (bno_q[1:0] == 2'h0 && (idx_q == 3'h4 || idx_q == 3'h5));
    end else if (st_q == S_WAIT && slot_tick && ctrl_q[CTRL_UNSYNC] && !usent_q &&
                 secs_q >= 10'(UNSYNC_MIN_S) && secs_q < 10'(UNSYNC_MAX_S) && !all_ok &&
                 secs_q < 10'(START_LIM_S)) begin
      o_tx_key     <= '1;
      o_tx_unsync  <= '1;
      o_tx_chan_b  <= '0;
      o_tx_msg14   <= '0;
      o_nav_status <= NAV_ACTIVE;
    end else if (slot_tick) begin
      o_tx_key <= '0;
    end
  end

  // Late flag when no synchronized transmission five minutes in
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || act) begin
      late_q    <= '0;
      abandon_q <= '0;
    end else begin
      if (!test_q && !synced_q && secs_q >= 10'(SYNC_LIM_S)) begin
        late_q <= '1;
      end
      if (st_q == S_TWAIT && !lock_s && secs_q >= 10'(TEST_LIM_S)) begin
        abandon_q <= '1;
      end
    end
  end

  // Distress signalling: wait for an idle channel, then stream symbols
  assign fsk.key = o_dsc_key;
  assign fsk.sym = sym_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || wd_trip_q) begin
      dsc_pend_q    <= '0;
      o_dsc_key     <= '0;
      o_dsc_bit_req <= '0;
      o_dsc_tone    <= '0;
      sym_q         <= '0;
      symcnt_q      <= '0;
    end else begin
      o_dsc_tone    <= fsk.tone;
      o_dsc_bit_req <= fsk.sym_req;
      if (wr_go && awa_q == ADDR_CTRL && wd_data_q[CTRL_DSC_GO]) begin
        dsc_pend_q <= '1;
      end else if (dsc_pend_q && !o_dsc_key && !busy_s) begin
        dsc_pend_q <= '0;
        o_dsc_key  <= dsclen_q != '0;
        symcnt_q   <= dsclen_q;
        sym_q      <= bit_s;
      end else if (o_dsc_key && fsk.sym_req) begin
        sym_q    <= bit_s;
        symcnt_q <= symcnt_q - 8'h01;
        if (symcnt_q == 8'h01) begin
          o_dsc_key <= '0;
        end
      end
    end
  end

  // AXI4-Lite write path; address and data taken in either order
  assign wr_go = !o_axi_awready && !o_axi_wready && !o_axi_bvalid;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_axi_awready <= '1;
      o_axi_wready  <= '1;
      o_axi_bvalid  <= '0;
      o_axi_bresp   <= RESP_OKAY;
      awa_q         <= '0;
      wd_data_q     <= '0;
      wstb_q        <= '0;
      ctrl_q        <= '0;
      dsclen_q      <= DSCLEN_RST;
      slotoff_q     <= SLOTOFF_RST;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        awa_q         <= i_axi_awaddr;
        o_axi_awready <= '0;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        // Strobes travel with the data; the master may drop them once W is taken
        wd_data_q    <= i_axi_wdata;
        wstb_q       <= i_axi_wstrb;
        o_axi_wready <= '0;
      end
      if (wr_go) begin
        o_axi_bvalid <= '1;
        o_axi_bresp  <= RESP_OKAY;
        unique case (awa_q)
          ADDR_CTRL: begin
            if (wstb_q[0]) ctrl_q <= {1'h0, wd_data_q[2:0]};
          end
          ADDR_DSCLEN: begin
            if (wstb_q[0]) dsclen_q <= wd_data_q[7:0];
          end
          ADDR_SLOTOFF: begin
            if (wstb_q[0]) slotoff_q[7:0] <= wd_data_q[7:0];
            if (wstb_q[1]) slotoff_q[11:8] <= wd_data_q[11:8];
          end
          default: o_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid  <= '0;
        o_axi_awready <= '1;
        o_axi_wready  <= '1;
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_axi_arready <= '1;
      o_axi_rvalid  <= '0;
      o_axi_rdata   <= '0;
      o_axi_rresp   <= RESP_OKAY;
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_arready <= '0;
      o_axi_rvalid  <= '1;
      o_axi_rresp   <= RESP_OKAY;
      unique case (i_axi_araddr)
        ADDR_CTRL:    o_axi_rdata <= {28'h0, ctrl_q};
        ADDR_DSCLEN:  o_axi_rdata <= {24'h0, dsclen_q};
        ADDR_SLOTOFF: o_axi_rdata <= {20'h0, slotoff_q};
        ADDR_STATUS:  o_axi_rdata <= {22'h0, st_q, dsc_pend_q || o_dsc_key, lock_s,
                                      fix_s, wd_trip_q, abandon_q, late_q, started_q};
        ADDR_LAT:     o_axi_rdata <= {5'h0, o_lat};
        ADDR_LON:     o_axi_rdata <= {4'h0, o_lon};
        ADDR_SECS:    o_axi_rdata <= {22'h0, secs_q};
        default: begin
          o_axi_rdata <= '0;
          o_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid  <= '0;
      o_axi_arready <= '1;
    end
  end

  // Helper for checks: slot ticks between transmission starts
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      gap_q   <= '0;
      key_d_q <= '0;
    end else begin
      key_d_q <= o_tx_key;
      if (o_tx_key && !key_d_q) gap_q <= '0;
      else if (slot_tick && gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end
  end

  chk_wdog_cut: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    wd_trip_q |=> !o_tx_key && !o_dsc_key) else $error("key active after cutoff");
  chk_lbt_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_dsc_key) |-> !$past(busy_s)) else $error("signalling on busy channel");
  chk_nav_active: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_tx_key) && !test_q |-> o_nav_status == NAV_ACTIVE && !o_tx_text_test)
    else $error("wrong active status");
  chk_nav_test: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_tx_key) && test_q && !o_tx_unsync |-> o_nav_status == NAV_TEST && o_tx_text_test)
    else $error("wrong test status");
  chk_burst_gap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_tx_key) && st_q == S_BURST && idx_q != 3'h1 && !o_tx_unsync |->
    gap_q == 8'(TX_GAP_SLOTS) && o_tx_chan_b != $past(o_tx_chan_b, 1))
    else $error("burst spacing or channel wrong");
  chk_start_lim: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_q == S_WAIT |-> secs_q <= 10'(START_LIM_S)) else $error("active start late");
  chk_test_abort: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_q == S_TWAIT && !lock_s && secs_q >= 10'(TEST_LIM_S) |=> st_q == S_DONE ##1 !o_tx_key)
    else $error("test mode not abandoned");
  chk_test_once: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_q == S_DONE && $past(st_q) == S_DONE |-> !$rose(o_tx_key))
    else $error("transmission after test burst");
  chk_keep_on: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_q == S_BURST && !test_q && ctrl_q[CTRL_RUN] |=> st_q == S_BURST)
    else $error("active transmission stopped");
  cov_active_burst: cover property (@(posedge i_sys_clk) fire && idx_q == 3'h7 && !test_q);
  cov_test_done: cover property (@(posedge i_sys_clk) st_q == S_DONE && !abandon_q);
  cov_dsc_sent: cover property (@(posedge i_sys_clk) $fell(o_dsc_key) && !wd_trip_q);
endmodule
`default_nettype wire
